// ===== common/mas_pkg.sv
// Purpose: Shared constants and types for the memory access steering block
// Assumes: 32-bit APB register bus, 10 MHz system clock
// Notes: Register offsets are byte addresses, one aligned word each
package mas_pkg;
  // APB geometry
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_DPSEL = 12'h004;
  localparam logic [11:0] OFS_PTR0_LO = 12'h008;
  localparam logic [11:0] OFS_PTR0_HI = 12'h00C;
  localparam logic [11:0] OFS_PTR1_LO = 12'h010;
  localparam logic [11:0] OFS_PTR1_HI = 12'h014;
  localparam logic [11:0] OFS_CMD = 12'h018;
  localparam logic [11:0] OFS_ADDR = 12'h01C;
  localparam logic [11:0] OFS_STATUS = 12'h020;
  localparam logic [11:0] OFS_PORT = 12'h024;
  // Control register fields (power_mgmt_register image)
  localparam int unsigned CTRL_SRAM_EN_BIT = 0;
  localparam int unsigned CTRL_WAIT_EN_BIT = 1;
  localparam int unsigned CTRL_P40_BIT = 2;
  localparam int unsigned CTRL_STRETCH_LSB = 4;
  localparam int unsigned STRETCH_W = 3;
  localparam logic [2:0] STRETCH_RST = 3'h1;
  // Status register fields
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_SRAM_BIT = 1;
  localparam int unsigned STAT_EXT_BIT = 2;
  localparam int unsigned STAT_RDATA_LSB = 8;
  // Command field positions and opcodes
  localparam int unsigned CMD_WDATA_LSB = 8;
  localparam logic [7:0] OP_FETCH = 8'h01;
  localparam logic [7:0] OP_PREAD = 8'h02;
  localparam logic [7:0] OP_XREAD = 8'h03;
  localparam logic [7:0] OP_XWRITE = 8'h04;
  localparam logic [7:0] OP_PTR_DEC = 8'hA5;
  // Machine cycle timing in oscillator clocks
  localparam int unsigned MC_CLKS = 4;
  localparam logic [1:0] PH_LAST = 2'(MC_CLKS - 1);
  localparam logic [1:0] ALE_LAST = 2'h1;
  // Memory map
  localparam int unsigned SRAM_AW = 10;
  localparam int unsigned SRAM_WORDS = 1024;
  localparam logic [15:0] SRAM_LIMIT = 16'h03FF;
  localparam logic [15:0] ROM_LIMIT = 16'h7FFF;
  localparam int unsigned ROM_AW = 15;
  // Port reset values
  localparam logic [7:0] PORT_RST = 8'hFF;
  localparam logic [7:0] OE_ALL = 8'hFF;
  localparam logic [7:0] OE_NONE = 8'h00;
  // Sequencer states
  typedef enum logic [2:0] {S_IDLE, S_INT, S_FIN, S_ADDR, S_STROBE} mas_state_t;
endpackage : mas_pkg

// ===== common/mas_sram_if.sv
// Purpose: Request and answer wires between sequencer and on-chip data SRAM
// Assumes: Read data valid one clock after the enabled cycle
// Notes: No clocking, plain wires
`timescale 1ns/1ps
interface mas_sram_if;
  logic en;
  logic we;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : mas_sram_if

// ===== verilog/mas_sram.sv
// Purpose: 1 KB on-chip data SRAM reached only by data moves
// Assumes: Single port, synchronous write and registered read
// Notes: Contents are not reset, like a real macro
`timescale 1ns/1ps
module mas_sram (
  // Clock
  input wire logic sys_clk_i,
  // Access port
  mas_sram_if.mem bus
);
  import mas_pkg::*;

  logic [7:0] mem_q [SRAM_WORDS];
  logic [7:0] rdata_q;

  // Write on enable, read data registered so the path stays short
  always_ff @(posedge sys_clk_i) begin
    if (bus.en && bus.we) begin
      mem_q[bus.addr] <= bus.wdata;
    end
    if (bus.en) begin
      rdata_q <= mem_q[bus.addr];
    end
  end

  assign bus.rdata = rdata_q;
endmodule : mas_sram

// ===== verilog/mas_steer.sv
// Purpose: Steers fetches, program reads and data moves to ROM, SRAM or bus
// Assumes: Core issues accesses through the APB command register
// Notes: All pin outputs are registered; pin inputs pass two flip-flops
//
// Summary of operation
// - On-chip SRAM covers data addresses 0000H-03FFH, data moves only, never fetches.
// - Low 1 KB data moves go to SRAM only while the enable bit is one.
// - Reset clears the SRAM enable, sending every data move to the bus.
// - External data move length is programmable from two to nine machine cycles.
// - A machine cycle lasts four clocks; bus phases are timed in these.
// - The A5H command decrements the active data pointer by exactly one.
// - A second 16-bit pointer sits in two extra byte registers.
// - Port 0 drives address/data during external accesses, else acts open-drain.
// - Port 2 drives the upper address byte while port 0 is multiplexed.
// - With waits enabled, port 4 bit 0 is input only.
// - Port 3 bit 6 is the write strobe, bit 7 the read strobe.
// - Program space is 64 KB, 32 KB on chip; above goes external.
// - Scratchpad RAM and data SRAM are separate, selected by instruction kind.
// - With SRAM enabled, data moves above 03FFH go to the external bus.
// - External access input high and address under 32 KB keeps ROM off-bus.
// - Program store strobe never pulses for internally served program reads.
// - Pointer select one picks the second pointer, zero the first.
`timescale 1ns/1ps
module mas_steer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [mas_pkg::APB_AW-1:0] paddr_i,
  input wire logic [mas_pkg::APB_DW-1:0] pwdata_i,
  output logic pready_o,
  output logic [mas_pkg::APB_DW-1:0] prdata_o,
  output logic pslverr_o,
  // Pins from the outside world
  input wire logic external_access_i,
  input wire logic wait_i,
  input wire logic [7:0] p0_i,
  // Multiplexed bus pins
  output logic [7:0] p0_o,
  output logic [7:0] p0_oe_o,
  output logic [7:0] p2_o,
  output logic [7:0] p2_oe_o,
  output logic ale_o,
  output logic program_store_strobe_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic p4_0_o,
  output logic p4_0_oe_o,
  // On-chip ROM port
  output logic rom_rd_o,
  output logic [mas_pkg::ROM_AW-1:0] rom_addr_o,
  input wire logic [7:0] rom_data_i
);
  import mas_pkg::*;

  mas_sram_if sram_bus ();

  mas_sram u_sram (
    .sys_clk_i(sys_clk_i),
    .bus(sram_bus.mem)
  );

  // Two-stage synchronisers for pin inputs
  logic ea_m_q, ea_s_q, wait_m_q, wait_s_q;
  logic [7:0] p0_m_q, p0_s_q;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ea_m_q <= 1'b0;
      ea_s_q <= 1'b0;
      wait_m_q <= 1'b0;
      wait_s_q <= 1'b0;
      p0_m_q <= 8'h00;
      p0_s_q <= 8'h00;
    end else begin
      ea_m_q <= external_access_i;
      ea_s_q <= ea_m_q;
      wait_m_q <= wait_i;
      wait_s_q <= wait_m_q;
      p0_m_q <= p0_i;
      p0_s_q <= p0_m_q;
    end
  end

  // State of registers and sequencer
  logic sram_en_q, sram_en_d, wait_en_q, wait_en_d, p40_lat_q, p40_lat_d;
  logic psel_bit_q, psel_bit_d;
  logic [2:0] stretch_q, stretch_d, mc_left_q, mc_left_d;
  logic [15:0] ptr0_q, ptr0_d, ptr1_q, ptr1_d, addr_q, addr_d, xaddr_q, xaddr_d;
  logic [7:0] p0_lat_q, p0_lat_d, p2_lat_q, p2_lat_d, op_q, op_d;
  logic [7:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [1:0] phase_q, phase_d;
  logic tgt_sram_q, tgt_sram_d, tgt_ext_q, tgt_ext_d;
  mas_state_t state_q, state_d;
  // Registered outputs
  logic pready_d, pslverr_d, ale_d, program_store_strobe_n_d, wr_n_d, rd_n_d, p40_oe_d, rom_rd_d;
  logic [31:0] prdata_d;
  logic [7:0] p0_d, p0_oe_d, p2_d, p2_oe_d;
  logic [14:0] rom_addr_d;
  // Decode helpers
  logic apb_wr, busy, cmd_go, is_data;
  logic [15:0] act_ptr;
  logic [7:0] cmd_op;

  assign apb_wr = psel_i & penable_i & pwrite_i & pready_o;
  assign busy = (state_q != S_IDLE);
  assign act_ptr = psel_bit_q ? ptr1_q : ptr0_q;
  assign cmd_op = pwdata_i[7:0];
  assign cmd_go = apb_wr && (paddr_i == OFS_CMD) && !busy;
  assign is_data = (op_q == OP_XREAD) || (op_q == OP_XWRITE);

  // SRAM port: only data moves reach it, scratchpad traffic never comes here
  assign sram_bus.en = (state_q == S_INT) && tgt_sram_q;
  assign sram_bus.we = (op_q == OP_XWRITE);
  assign sram_bus.addr = xaddr_q[SRAM_AW-1:0];
  assign sram_bus.wdata = wdata_q;

  // Register writes and access sequencer
  always_comb begin
    sram_en_d = sram_en_q;
    wait_en_d = wait_en_q;
    p40_lat_d = p40_lat_q;
    stretch_d = stretch_q;
    psel_bit_d = psel_bit_q;
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    addr_d = addr_q;
    p0_lat_d = p0_lat_q;
    p2_lat_d = p2_lat_q;
    state_d = state_q;
    op_d = op_q;
    xaddr_d = xaddr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    phase_d = phase_q;
    mc_left_d = mc_left_q;
    tgt_sram_d = tgt_sram_q;
    tgt_ext_d = tgt_ext_q;
    if (apb_wr) begin
      case (paddr_i)
        OFS_CTRL: begin
          sram_en_d = pwdata_i[CTRL_SRAM_EN_BIT];
          wait_en_d = pwdata_i[CTRL_WAIT_EN_BIT];
          p40_lat_d = pwdata_i[CTRL_P40_BIT];
          stretch_d = pwdata_i[CTRL_STRETCH_LSB +: STRETCH_W];
        end
        OFS_DPSEL: psel_bit_d = pwdata_i[0];
        OFS_PTR0_LO: ptr0_d[7:0] = pwdata_i[7:0];
        OFS_PTR0_HI: ptr0_d[15:8] = pwdata_i[7:0];
        OFS_PTR1_LO: ptr1_d[7:0] = pwdata_i[7:0];
        OFS_PTR1_HI: ptr1_d[15:8] = pwdata_i[7:0];
        OFS_ADDR: addr_d = pwdata_i[15:0];
        OFS_PORT: begin
          p0_lat_d = pwdata_i[7:0];
          p2_lat_d = pwdata_i[15:8];
        end
        default: ;
      endcase
    end
    case (state_q)
      S_IDLE: begin
        if (cmd_go) begin
          op_d = cmd_op;
          wdata_d = pwdata_i[CMD_WDATA_LSB +: 8];
          phase_d = 2'h0;
          case (cmd_op)
            OP_PTR_DEC: begin
              // Pointer arithmetic wraps at 16 bits
              if (psel_bit_q) begin
                ptr1_d = ptr1_q - 16'h0001;
              end else begin
                ptr0_d = ptr0_q - 16'h0001;
              end
            end
            OP_FETCH, OP_PREAD: begin
              // Program space never touches the data SRAM
              xaddr_d = addr_q;
              tgt_sram_d = 1'b0;
              tgt_ext_d = !(ea_s_q && (addr_q <= ROM_LIMIT));
              state_d = tgt_ext_d ? S_ADDR : S_INT;
            end
            OP_XREAD, OP_XWRITE: begin
              xaddr_d = act_ptr;
              tgt_sram_d = sram_en_q && (act_ptr <= SRAM_LIMIT);
              tgt_ext_d = !tgt_sram_d;
              state_d = tgt_sram_d ? S_INT : S_ADDR;
            end
            default: ;
          endcase
        end
      end
      S_INT: state_d = S_FIN;
      S_FIN: begin
        // Internal answer is ready one clock after the enabled cycle
        if (op_q != OP_XWRITE) begin
          rdata_d = tgt_sram_q ? sram_bus.rdata : rom_data_i;
        end
        state_d = S_IDLE;
      end
      S_ADDR: begin
        // Address phase is one machine cycle
        phase_d = phase_q + 2'h1;
        if (phase_q == PH_LAST) begin
          state_d = S_STROBE;
          phase_d = 2'h0;
          mc_left_d = is_data ? stretch_q : 3'h0;
        end
      end
      S_STROBE: begin
        if (phase_q != PH_LAST) begin
          phase_d = phase_q + 2'h1;
        end else if (mc_left_q != 3'h0) begin
          mc_left_d = mc_left_q - 3'h1;
          phase_d = 2'h0;
        end else if (is_data && wait_en_q && wait_s_q) begin
          state_d = S_STROBE;
        end else begin
          // Synchroniser delay: bus data must be valid two clocks early
          if (op_q != OP_XWRITE) begin
            rdata_d = p0_s_q;
          end
          state_d = S_IDLE;
          phase_d = 2'h0;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // Pin and bus outputs follow the next state so they leave a flip-flop
  always_comb begin
    ale_d = (state_d == S_ADDR) && (phase_d <= ALE_LAST);
    program_store_strobe_n_d = 1'b1;
    wr_n_d = 1'b1;
    rd_n_d = 1'b1;
    p0_d = 8'h00;
    p0_oe_d = ~p0_lat_d;
    p2_d = p2_lat_d;
    p2_oe_d = ~p2_lat_d;
    if (state_d == S_ADDR) begin
      p0_d = xaddr_d[7:0];
      p0_oe_d = OE_ALL;
    end else if (state_d == S_STROBE) begin
      program_store_strobe_n_d = !((op_d == OP_FETCH) || (op_d == OP_PREAD));
      wr_n_d = (op_d != OP_XWRITE);
      rd_n_d = (op_d != OP_XREAD);
      p0_d = (op_d == OP_XWRITE) ? wdata_d : 8'h00;
      p0_oe_d = (op_d == OP_XWRITE) ? OE_ALL : OE_NONE;
    end
    if ((state_d == S_ADDR) || (state_d == S_STROBE)) begin
      p2_d = xaddr_d[15:8];
      p2_oe_d = OE_ALL;
    end
    // Wait pin is never driven while it carries wait requests
    p40_oe_d = !wait_en_d && !p40_lat_d;
    rom_rd_d = (state_d == S_INT) && !tgt_sram_d;
    rom_addr_d = xaddr_d[ROM_AW-1:0];
  end

  // APB answer: ready in the first access cycle, decoded during setup
  always_comb begin
    pready_d = psel_i && !penable_i;
    pslverr_d = 1'b0;
    prdata_d = prdata_o;
    if (psel_i && !penable_i) begin
      prdata_d = 32'h0000_0000;
      case (paddr_i)
        OFS_CTRL: begin
          prdata_d[CTRL_SRAM_EN_BIT] = sram_en_q;
          prdata_d[CTRL_WAIT_EN_BIT] = wait_en_q;
          prdata_d[CTRL_P40_BIT] = p40_lat_q;
          prdata_d[CTRL_STRETCH_LSB +: STRETCH_W] = stretch_q;
        end
        OFS_DPSEL: prdata_d[0] = psel_bit_q;
        OFS_PTR0_LO: prdata_d[7:0] = ptr0_q[7:0];
        OFS_PTR0_HI: prdata_d[7:0] = ptr0_q[15:8];
        OFS_PTR1_LO: prdata_d[7:0] = ptr1_q[7:0];
        OFS_PTR1_HI: prdata_d[7:0] = ptr1_q[15:8];
        OFS_ADDR: prdata_d[15:0] = addr_q;
        OFS_CMD: prdata_d[7:0] = op_q;
        OFS_PORT: prdata_d[15:0] = {p2_lat_q, p0_lat_q};
        OFS_STATUS: begin
          prdata_d[STAT_BUSY_BIT] = busy;
          prdata_d[STAT_SRAM_BIT] = tgt_sram_q;
          prdata_d[STAT_EXT_BIT] = tgt_ext_q;
          prdata_d[STAT_RDATA_LSB +: 8] = rdata_q;
        end
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  // Register every group; reset clears the SRAM enable and idles the bus
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sram_en_q <= 1'b0;
      wait_en_q <= 1'b0;
      p40_lat_q <= 1'b1;
      stretch_q <= STRETCH_RST;
      psel_bit_q <= 1'b0;
      ptr0_q <= 16'h0000;
      ptr1_q <= 16'h0000;
      addr_q <= 16'h0000;
      p0_lat_q <= PORT_RST;
      p2_lat_q <= PORT_RST;
      state_q <= S_IDLE;
      op_q <= 8'h00;
      xaddr_q <= 16'h0000;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      phase_q <= 2'h0;
      mc_left_q <= 3'h0;
      tgt_sram_q <= 1'b0;
      tgt_ext_q <= 1'b0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      ale_o <= 1'b0;
      program_store_strobe_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      p0_o <= 8'h00;
      p0_oe_o <= OE_NONE;
      p2_o <= PORT_RST;
      p2_oe_o <= OE_NONE;
      p4_0_o <= 1'b0;
      p4_0_oe_o <= 1'b0;
      rom_rd_o <= 1'b0;
      rom_addr_o <= 15'h0000;
    end else begin
      sram_en_q <= sram_en_d;
      wait_en_q <= wait_en_d;
      p40_lat_q <= p40_lat_d;
      stretch_q <= stretch_d;
      psel_bit_q <= psel_bit_d;
      ptr0_q <= ptr0_d;
      ptr1_q <= ptr1_d;
      addr_q <= addr_d;
      p0_lat_q <= p0_lat_d;
      p2_lat_q <= p2_lat_d;
      state_q <= state_d;
      op_q <= op_d;
      xaddr_q <= xaddr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      phase_q <= phase_d;
      mc_left_q <= mc_left_d;
      tgt_sram_q <= tgt_sram_d;
      tgt_ext_q <= tgt_ext_d;
      pready_o <= pready_d;
      pslverr_o <= pslverr_d;
      prdata_o <= prdata_d;
      ale_o <= ale_d;
      program_store_strobe_n_o <= program_store_strobe_n_d;
      wr_n_o <= wr_n_d;
      rd_n_o <= rd_n_d;
      p0_o <= p0_d;
      p0_oe_o <= p0_oe_d;
      p2_o <= p2_d;
      p2_oe_o <= p2_oe_d;
      p4_0_o <= 1'b0;
      p4_0_oe_o <= p40_oe_d;
      rom_rd_o <= rom_rd_d;
      rom_addr_o <= rom_addr_d;
    end
  end

  // Helper logic for the checks below: write strobe width and its stretch
  logic [7:0] wr_len_q;
  logic [2:0] exp_q;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      wr_len_q <= 8'h00;
      exp_q <= 3'h0;
    end else begin
      wr_len_q <= wr_n_o ? 8'h00 : wr_len_q + 8'h01;
      if ((state_q == S_ADDR) && (state_d == S_STROBE)) begin
        exp_q <= stretch_q;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_sram_map;
    sram_bus.en |-> is_data && (xaddr_q <= SRAM_LIMIT) && sram_en_q;
  endproperty
  a_sram_map: assert property (p_sram_map) else $error("SRAM hit outside map");
  property p_sram_gate;
    cmd_go && (cmd_op == OP_XREAD) && !sram_en_q |=> state_q == S_ADDR;
  endproperty
  a_sram_gate: assert property (p_sram_gate) else $error("Disabled SRAM used");
  property p_reset_clear;
    disable iff (1'b0) !reset_n_i |=> !sram_en_q && (state_q == S_IDLE);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Reset left SRAM on");
  property p_xfer_len;
    $rose(wr_n_o) && !wait_en_q |-> wr_len_q == 8'(({5'h00, exp_q} + 8'h01) << 2);
  endproperty
  a_xfer_len: assert property (p_xfer_len) else $error("Write strobe width wrong");
  property p_mc_addr;
    // Latch enable is high for two clocks, low for two, then a strobe opens
    $rose(ale_o) |-> ##1 ale_o ##1 !ale_o [*2]
      ##1 (!wr_n_o || !rd_n_o || !program_store_strobe_n_o);
  endproperty
  a_mc_addr: assert property (p_mc_addr) else $error("Address phase not four clocks");
  property p_dec;
    cmd_go && (cmd_op == OP_PTR_DEC) |=> act_ptr == $past(act_ptr) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("Pointer not decremented by one");
  property p_addr_drive;
    ale_o |-> (p0_oe_o == OE_ALL) && (p2_oe_o == OE_ALL) && (p2_o == xaddr_q[15:8]);
  endproperty
  a_addr_drive: assert property (p_addr_drive) else $error("Address not driven");
  property p_wait_input;
    // Both flops load from the same next value, so they agree in one cycle
    wait_en_q |-> !p4_0_oe_o;
  endproperty
  a_wait_input: assert property (p_wait_input) else $error("Wait pin driven");
  property p_program_store_strobe_int;
    rom_rd_o |-> program_store_strobe_n_o ##1 program_store_strobe_n_o;
  endproperty
  a_program_store_strobe_int: assert property (p_program_store_strobe_int) else $error("Strobe on internal ROM read");
  property p_wait_hold;
    (state_q == S_STROBE) && (phase_q == PH_LAST) && (mc_left_q == 3'h0) && is_data
      && wait_en_q && wait_s_q |=> (state_q == S_STROBE) && (!wr_n_o || !rd_n_o);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("Wait not honoured");

  c_sram_write: cover property (sram_bus.en && sram_bus.we);
  c_long_write: cover property ($rose(wr_n_o) && (exp_q == 3'h7));
  c_wait_ext: cover property ((state_q == S_STROBE) && wait_s_q && wait_en_q ##1 !rd_n_o);
  c_rom_fetch: cover property (rom_rd_o && (op_q == OP_FETCH));
endmodule : mas_steer

// ===== tb/mas_ext_mem.sv
// Purpose: External program and data memory on the multiplexed bus
// Assumes: Address is latched while ale is high
// Notes: Released port 0 bits show the inverse of the latched byte
`timescale 1ns/1ps
module mas_ext_mem (
  // Bus pins from the block
  input wire logic clk_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic program_store_strobe_n_i,
  input wire logic [7:0] p0_i,
  input wire logic [7:0] p0_oe_i,
  input wire logic [7:0] p2_i,
  // Bench command: strobe clocks to hold wait
  input wire logic [7:0] wait_clks_i,
  // Pins driven back
  output logic [7:0] p0_o,
  output logic wait_o
);
  logic [7:0] mem [0:65535];
  logic [15:0] a_q = 16'h0000;
  logic [7:0] n_q = 8'h00;
  wire strb = !rd_n_i || !wr_n_i;
  wire drv = !rd_n_i || !program_store_strobe_n_i;
  // Seeded contents keep untouched reads predictable
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8);
  // Latch address, capture writes, count strobe clocks
  always @(posedge clk_i) begin
    if (ale_i) a_q <= {p2_i, p0_i};
    if (!wr_n_i) mem[a_q] <= p0_i;
    n_q <= strb ? n_q + 8'h01 : 8'h00;
  end
  // Wait only during data strobes; a slow device answers late
  assign wait_o = strb && (n_q < wait_clks_i);
  assign p0_o = drv ? mem[a_q] : (p0_oe_i & p0_i) | (~p0_oe_i & ~a_q[7:0]);
endmodule : mas_ext_mem

// ===== tb/mas_steer_tb.sv
// Purpose: Self-checking bench for the memory access steering block
// Assumes: APB master tasks, external memory model on the bus pins
// Notes: Random data and addresses from a fixed-seed xorshift
`timescale 1ns/1ps
module mas_steer_tb;
  import mas_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, xa = 1'b1;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0000_0000, rd, seed = 32'hbf9c_163f;
  logic [7:0] wclks = 8'h00;
  logic e;
  int n_mismatch = 0, checks = 0, wlen = 0, rlen = 0, cnt = 0, n_program_store_strobe = 0, n_rom = 0, r0 = 0;
  wire pready, perr, ale, psn, wr_n, rd_n, p4, p4oe, wt, rrd;
  wire [31:0] prd;
  wire [7:0] p0o, p0oe, p2o, p2oe, p0w;
  wire [14:0] ra;
  initial forever #50 clk = ~clk;
  mas_steer uut (.sys_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pready_o(pready), .prdata_o(prd),
    .pslverr_o(perr), .external_access_i(xa), .wait_i(wt), .p0_i(p0w), .p0_o(p0o),
    .p0_oe_o(p0oe), .p2_o(p2o), .p2_oe_o(p2oe), .ale_o(ale),
    .program_store_strobe_n_o(psn), .wr_n_o(wr_n), .rd_n_o(rd_n), .p4_0_o(p4),
    .p4_0_oe_o(p4oe), .rom_rd_o(rrd), .rom_addr_o(ra), .rom_data_i(ra[7:0] ^ 8'h3C));
  mas_ext_mem ext (.clk_i(clk), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n), .program_store_strobe_n_i(psn),
    .p0_i(p0o), .p0_oe_i(p0oe), .p2_i(p2o), .wait_clks_i(wclks), .p0_o(p0w), .wait_o(wt));
  // Strobe lengths, program strobe clocks, drive during address phases
  always @(posedge clk) begin
    cnt = (!wr_n || !rd_n) ? cnt + 1 : 0;
    if (!wr_n) wlen = cnt;
    if (!rd_n) rlen = cnt;
    if (!psn) n_program_store_strobe++;
    if (rrd) n_rom++;
    if (ale) chk("bus drive", 32'h0000_FFFF, {16'h0, p0oe, p2oe});
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Target bits {ext, sram} expected for a data move
  function automatic logic [1:0] tgt(input logic en, input logic [15:0] a);
    return (en && a <= SRAM_LIMIT) ? 2'b01 : 2'b10;
  endfunction : tgt
  function automatic logic [7:0] mem0(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction : mem0
  function automatic int stl(input int s);
    return MC_CLKS * (s + 1);
  endfunction : stl
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic hang(input int i, input int lim);
    if (i >= lim) begin
      n_mismatch++;
      $display("[FAIL] wait expected done seen timeout");
      end_of_test();
    end
  endtask : hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic er);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
    hang(i, 20);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic er;
    apb(1'b1, a, d, er);
  endtask : wr
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
    logic er;
    apb(1'b0, a, 32'h0, er);
    chk(nm, x, rd);
  endtask : rdc
  // Issue a command, then poll status until idle
  task automatic cmd(input logic [7:0] op, input logic [7:0] d);
    logic er;
    int i;
    wr(OFS_CMD, {16'h0, d, op});
    for (i = 0; i < 200; i++) begin
      apb(1'b0, OFS_STATUS, 32'h0, er);
      if (rd[STAT_BUSY_BIT] === 1'b0) break;
    end
    hang(i, 200);
  endtask : cmd
  // Write then read one data byte through pointer 0; len < 0 skips timing
  task automatic move(input logic en, input logic [15:0] a, input int len);
    logic [7:0] d;
    logic [1:0] t;
    d = 8'(xs());
    t = tgt(en, a);
    wlen = 0;
    rlen = 0;
    wr(OFS_PTR0_LO, {24'h0, a[7:0]});
    wr(OFS_PTR0_HI, {24'h0, a[15:8]});
    cmd(OP_XWRITE, d);
    chk("write target", {29'h0, t, 1'b0}, rd & 32'h6);
    cmd(OP_XREAD, 8'h00);
    chk("read back", {16'h0, d, 5'h0, t, 1'b0}, rd & 32'hFF06);
    chk("ext copy", {24'h0, t[0] ? mem0(a) : d}, {24'h0, ext.mem[a]});
    if (len >= 0) chk("strobe clocks", t[1] ? {2{16'(len)}} : 32'h0,
                      {16'(wlen), 16'(rlen)});
  endtask : move
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    logic [15:0] p, fa;
    logic ex;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdc("ctrl reset", OFS_CTRL, 32'h0000_0014);
    rdc("dpsel reset", OFS_DPSEL, 32'h0000_0000);
    rdc("port reset", OFS_PORT, 32'h0000_FFFF);
    apb(1'b0, 12'h028, 32'h0, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    $display("test registers done");
    // Decrement borrows across bytes; select picks the second pointer
    wr(OFS_PTR0_HI, 32'h0000_0012);
    cmd(OP_PTR_DEC, 8'h00);
    rdc("ptr0 low", OFS_PTR0_LO, 32'h0000_00FF);
    rdc("ptr0 high", OFS_PTR0_HI, 32'h0000_0011);
    p = 16'(xs());
    wr(OFS_PTR1_LO, {24'h0, p[7:0]});
    wr(OFS_PTR1_HI, {24'h0, p[15:8]});
    wr(OFS_DPSEL, 32'h1);
    cmd(OP_PTR_DEC, 8'h00);
    p = p - 16'h0001;
    rdc("ptr1 low", OFS_PTR1_LO, {24'h0, p[7:0]});
    rdc("ptr1 high", OFS_PTR1_HI, {24'h0, p[15:8]});
    rdc("ptr0 kept", OFS_PTR0_LO, 32'h0000_00FF);
    wr(OFS_DPSEL, 32'h0);
    $display("test pointers done");
    move(1'b0, 16'h0100, stl(1));
    wr(OFS_CTRL, 32'h0000_0005);
    move(1'b1, 16'h03FF, stl(0));
    move(1'b1, 16'h0000, stl(0));
    move(1'b1, 16'h0400, stl(0));
    $display("test steering done");
    for (int s = 0; s < 8; s += 7) begin
      wr(OFS_CTRL, 32'h4 | (32'(s) << CTRL_STRETCH_LSB));
      move(1'b0, {2'b01, 14'(xs())}, stl(s));
    end
    $display("test stretch done");
    // Slow device holds wait; then the same with waits disabled
    // Pin latch left at zero so only the wait enable keeps the pin undriven
    wr(OFS_CTRL, 32'h0000_0002);
    wclks <= 8'd10;
    move(1'b0, {2'b01, 14'(xs())}, -1);
    chk("p4 input only", 32'h0, {30'h0, p4, p4oe});
    chk("wait stretch", 32'h1, {31'h0, wlen > 4 && wlen <= 16 && rlen > 4});
    wr(OFS_CTRL, 32'h0000_0004);
    move(1'b0, {2'b01, 14'(xs())}, stl(0));
    wclks <= 8'd0;
    $display("test wait done");
    // Fetch and program read: ROM, ROM random, above ROM, access pin low
    for (int k = 0; k < 4; k++) begin
      fa = (k == 0) ? 16'h7FFF : (k == 1) ? {1'b0, 15'(xs())} : (k == 2) ? 16'h8000 : 16'h0010;
      xa <= (k != 3);
      wr(OFS_ADDR, {16'h0, fa});
      p = 16'(n_program_store_strobe);
      r0 = n_rom;
      cmd(k[0] ? OP_PREAD : OP_FETCH, 8'h00);
      ex = (k < 2);
      chk("prog read", {16'h0, ex ? fa[7:0] ^ 8'h3C : mem0(fa), 5'h0, !ex, 2'b00},
          rd & 32'hFF06);
      chk("program_store_strobe clocks", ex ? 0 : MC_CLKS, 32'(16'(n_program_store_strobe) - p));
      chk("rom pulses", ex ? 1 : 0, n_rom - r0);
    end
    $display("test program memory done");
    end_of_test();
  end
endmodule : mas_steer_tb
